// *** hw/output_sample_unpacker.sv ***
// Unpacks 16-bit memory words into samples for two pattern output channels.
// Assumes words arrive on a valid/ready stream, the sink stalls with
// SAMPLE_READY, and software drives the APB register port.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps

// Summary of operation
// RULE_01: Every input word is 16 bits; 8-bit samples are packed two per word, except in FIFO mode with channel 0 alone.
// RULE_02: Mapping chosen from output mode together with channel and width setting.
// RULE_03: Standard, channel 0 byte: bits 7..0 sample N, bits 15..8 sample N+1.
// RULE_04: Standard, 16-bit width: each word is one whole sample, bit 15 MSB.
// RULE_05: Standard, both byte channels: bits 15..8 channel 1, bits 7..0 channel 0.
// RULE_06: FIFO mode, single channel: consecutive words are consecutive channel 0 samples.
// RULE_07: FIFO mode, both 16-bit: words alternate channel 0 then channel 1.
// RULE_08: FIFO mode, both 8-bit: each word holds one sample pair.
// RULE_09: The filling party packs words in the layout of the chosen mode.
// RULE_10: Configuration is captured only at start and held while running.
module output_sample_unpacker #(
  parameter int WORD_W = unpacker_pkg::WORD_W,
  parameter int DEPTH = unpacker_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [unpacker_pkg::ADDR_W-1:0] PADDR,
  input wire logic [unpacker_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [unpacker_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Word stream from memory or host buffers
  input wire logic [WORD_W-1:0] WORD_DATA,
  input wire logic WORD_VALID,
  output logic WORD_READY,
  // Channel sample outputs
  output logic [WORD_W-1:0] CH0_DATA,
  output logic CH0_VALID,
  output logic [WORD_W-1:0] CH1_DATA,
  output logic CH1_VALID,
  input wire logic SAMPLE_READY
);

  localparam int LW = $clog2(DEPTH+1);
  localparam int BW = unpacker_pkg::BYTE_W;
  localparam int DW = unpacker_pkg::DATA_W;

  // Register state
  logic [7:0] ctrl;
  logic cfg_err;
  logic [DW-1:0] sample_count;
  logic [DW-1:0] rdata;
  unpacker_pkg::run_state_t state;
  unpacker_pkg::layout_t layout;

  // Datapath state
  logic phase;
  logic [WORD_W-1:0] held;
  logic out_valid;
  logic out_ch1;
  logic [WORD_W-1:0] out0;
  logic [WORD_W-1:0] out1;

  // FIFO draining side
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic [LW-1:0] fifo_level;

  // Input buffer; its ready stalls the word source
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .nrst(NRST),
    .wr_data(WORD_DATA),
    .wr_valid(WORD_VALID),
    .wr_ready(WORD_READY),
    .rd_data(fifo_data),
    .rd_valid(fifo_valid),
    .rd_ready(fifo_ready),
    .level(fifo_level)
  );

  // APB decode
  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE;
  wire hit_ctrl = PADDR == unpacker_pkg::CTRL_OFF;
  wire hit_status = PADDR == unpacker_pkg::STATUS_OFF;
  wire hit_count = PADDR == unpacker_pkg::COUNT_OFF;
  wire mapped = hit_ctrl || hit_status || hit_count;
  wire bad_write = PWRITE && !hit_ctrl;
  wire ctrl_wr = access && PWRITE && hit_ctrl && PSTRB[0];

  assign PREADY = 1'b1;
  assign PSLVERR = access && (!mapped || bad_write);
  assign PRDATA = rdata;

  // Control fields of the incoming write
  wire [7:0] wr_ctrl = PWDATA[7:0] & unpacker_pkg::CTRL_MASK;
  wire wr_run = wr_ctrl[unpacker_pkg::CTRL_RUN_BIT];
  wire wr_fifo = wr_ctrl[unpacker_pkg::CTRL_FIFO_MODE_BIT];
  wire chan0_byte_width = wr_ctrl[unpacker_pkg::CTRL_C0_BYTE_BIT];
  wire chan0_word_width = wr_ctrl[unpacker_pkg::CTRL_C0_WORD_BIT];
  wire chan1_byte_width = wr_ctrl[unpacker_pkg::CTRL_C1_BYTE_BIT];
  wire chan1_word_width = wr_ctrl[unpacker_pkg::CTRL_C1_WORD_BIT];

  // Mode and width decide the layout together [RULE_02]
  wire wr_cfg_ok = unpacker_pkg::cfg_ok(chan0_byte_width, chan0_word_width,
                                       chan1_byte_width, chan1_word_width);
  wire unpacker_pkg::layout_t wr_layout =
    unpacker_pkg::decode_layout(wr_fifo, chan0_byte_width,
                                chan1_byte_width, chan1_word_width);

  // Start and stop commands
  wire running = state == unpacker_pkg::ST_RUN;
  wire start_req = ctrl_wr && wr_run && !running;
  wire start = start_req && wr_cfg_ok;
  wire refuse = start_req && !wr_cfg_ok;
  wire stop = ctrl_wr && !wr_run && running;

  // Layout classes of the captured configuration
  wire split = layout == unpacker_pkg::LAY_STD_C0_BYTE;
  wire pair = layout == unpacker_pkg::LAY_STD_BOTH_WORD ||
              layout == unpacker_pkg::LAY_FIFO_BOTH_WORD;
  wire byte_pair = layout == unpacker_pkg::LAY_STD_BOTH_BYTE ||
                   layout == unpacker_pkg::LAY_FIFO_BOTH_BYTE;
  wire two_chan = pair || byte_pair;

  // Word handling: one take per word, two for split bytes
  wire slot_free = !out_valid || SAMPLE_READY;
  // A stop write takes no word, so the buffer keeps it for the next start
  wire take = running && !stop && fifo_valid && slot_free;
  wire pop = take && (!split || phase); // [RULE_03]
  wire emit = take && (!pair || phase); // [RULE_07]
  wire out_done = out_valid && SAMPLE_READY;

  assign fifo_ready = pop;

  // Word byte lanes [RULE_01]
  wire [BW-1:0] lo_byte = fifo_data[BW-1:0];
  wire [BW-1:0] hi_byte = fifo_data[WORD_W-1:BW];

  // Zero extends a byte sample to the output width
  function automatic logic [WORD_W-1:0] widen(input logic [BW-1:0] b);
    widen = WORD_W'(b);
  endfunction

  // Sample selection per layout
  logic [WORD_W-1:0] next_out0;
  logic [WORD_W-1:0] next_out1;

  always_comb begin
    next_out0 = fifo_data;
    next_out1 = '0;
    unique case (layout)
      unpacker_pkg::LAY_STD_C0_BYTE: begin
        // Low byte is sample N, high byte sample N+1 [RULE_03]
        next_out0 = widen(phase ? hi_byte : lo_byte);
      end
      unpacker_pkg::LAY_STD_C0_WORD,
      unpacker_pkg::LAY_FIFO_C0_WORD: begin
        // Whole word is one sample, bit 15 MSB [RULE_04] [RULE_06]
        next_out0 = fifo_data;
      end
      unpacker_pkg::LAY_FIFO_C0_BYTE: begin
        // One sample per buffer word, in order [RULE_06]
        next_out0 = widen(lo_byte);
      end
      unpacker_pkg::LAY_STD_BOTH_BYTE,
      unpacker_pkg::LAY_FIFO_BOTH_BYTE: begin
        // High byte channel 1, low byte channel 0 [RULE_05] [RULE_08]
        next_out0 = widen(lo_byte);
        next_out1 = widen(hi_byte);
      end
      unpacker_pkg::LAY_STD_BOTH_WORD,
      unpacker_pkg::LAY_FIFO_BOTH_WORD: begin
        // Held word is channel 0, current word channel 1 [RULE_07]
        next_out0 = held;
        next_out1 = fifo_data;
      end
    endcase
  end

  // Moves a status field to its bit position
  function automatic logic [DW-1:0] place(input logic [DW-1:0] v, input int pos);
    place = v << pos;
  endfunction

  // Read data for the access phase, captured during setup
  wire [DW-1:0] status_word =
    place(DW'(fifo_level), unpacker_pkg::STAT_LEVEL_LSB) |
    place(DW'(layout), unpacker_pkg::STAT_LAYOUT_LSB) |
    place(DW'(cfg_err), unpacker_pkg::STAT_CFG_ERR_BIT) |
    place(DW'(running), unpacker_pkg::STAT_RUNNING_BIT);

  wire [DW-1:0] next_rdata = hit_ctrl ? DW'(ctrl) :
                             hit_status ? status_word :
                             hit_count ? sample_count : '0;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata <= '0;
    end else if (setup && !PWRITE) begin
      rdata <= next_rdata;
    end
  end

  // Control register; stored always, used only at start [RULE_10]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl <= unpacker_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= wr_ctrl;
    end
  end

  // Next run state from the start and stop commands
  unpacker_pkg::run_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      unpacker_pkg::ST_IDLE: if (start) next_state = unpacker_pkg::ST_RUN;
      unpacker_pkg::ST_RUN: if (stop) next_state = unpacker_pkg::ST_IDLE;
    endcase
  end

  // Run state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= unpacker_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Layout captured once per start and frozen while running [RULE_10]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      layout <= unpacker_pkg::LAY_STD_C0_WORD;
    end else if (start) begin
      layout <= wr_layout;
    end
  end

  // Refused start flag, cleared by the next good start
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_err <= 1'b0;
    end else if (refuse) begin
      cfg_err <= 1'b1;
    end else if (start) begin
      cfg_err <= 1'b0;
    end
  end

  // Byte and channel phase within a word or word pair
  wire flip = take && (split || pair);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      phase <= 1'b0;
    end else if (!running) begin
      phase <= 1'b0;
    end else if (flip) begin
      phase <= !phase; // [RULE_03] [RULE_07]
    end
  end

  // Channel 0 word waiting for its channel 1 partner
  wire first_half = take && pair && !phase;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      held <= '0;
    end else if (first_half) begin
      held <= fifo_data; // [RULE_07]
    end
  end

  // Output stage flags; a stop drops a pending beat at once
  wire flush = !running || stop;
  wire next_out_valid = emit || (out_valid && !out_done);
  wire next_out_ch1 = emit ? two_chan : out_ch1 && !out_done;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_valid <= 1'b0;
    end else if (flush) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_ch1 <= 1'b0;
    end else if (flush) begin
      out_ch1 <= 1'b0;
    end else begin
      out_ch1 <= next_out_ch1;
    end
  end

  // Channel 0 output register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out0 <= '0;
    end else if (emit) begin
      out0 <= next_out0;
    end
  end

  // Channel 1 output register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out1 <= '0;
    end else if (emit) begin
      out1 <= next_out1;
    end
  end

  // Count of delivered sample beats, cleared at start
  wire [DW-1:0] next_count = sample_count + 1'b1;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sample_count <= unpacker_pkg::COUNT_RESET;
    end else if (start) begin
      sample_count <= unpacker_pkg::COUNT_RESET;
    end else if (out_done) begin
      sample_count <= next_count;
    end
  end

  assign CH0_DATA = out0;
  assign CH1_DATA = out1;
  assign CH0_VALID = out_valid;
  assign CH1_VALID = out_ch1;

endmodule

// *** inc/unpacker_pkg.sv ***
// Shared constants, layouts and decode functions for the sample unpacker.
// Assumes a single 100 MHz clock domain and an APB register port.
package unpacker_pkg;

  // Widths and depths
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_NS = 10;

  // Register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] COUNT_OFF = 12'h008;

  // Control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FIFO_MODE_BIT = 1;
  localparam int CTRL_C0_BYTE_BIT = 4;
  localparam int CTRL_C0_WORD_BIT = 5;
  localparam int CTRL_C1_BYTE_BIT = 6;
  localparam int CTRL_C1_WORD_BIT = 7;
  localparam logic [7:0] CTRL_MASK = 8'hf3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status field positions
  localparam int STAT_RUNNING_BIT = 0;
  localparam int STAT_CFG_ERR_BIT = 1;
  localparam int STAT_LAYOUT_LSB = 4;
  localparam int STAT_LEVEL_LSB = 8;

  // Reset values
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // Word-to-sample layouts
  typedef enum logic [2:0] {
    LAY_STD_C0_BYTE,
    LAY_STD_C0_WORD,
    LAY_STD_BOTH_BYTE,
    LAY_STD_BOTH_WORD,
    LAY_FIFO_C0_BYTE,
    LAY_FIFO_C0_WORD,
    LAY_FIFO_BOTH_BYTE,
    LAY_FIFO_BOTH_WORD
  } layout_t;

  typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

  // Only the four documented channel and width combinations are legal
  function automatic logic cfg_ok(input logic c0b, input logic c0w,
                                  input logic c1b, input logic c1w);
    cfg_ok = (c0b ^ c0w) && !(c1b && c1w) && !(c1b && c0w) && !(c1w && c0b);
  endfunction

  function automatic layout_t decode_layout(input logic fifo, input logic c0b,
                                            input logic c1b, input logic c1w);
    logic [2:0] sel;
    sel = {fifo, c1b | c1w, c0b};
    unique case (sel)
      3'h1: decode_layout = LAY_STD_C0_BYTE;
      3'h0: decode_layout = LAY_STD_C0_WORD;
      3'h3: decode_layout = LAY_STD_BOTH_BYTE;
      3'h2: decode_layout = LAY_STD_BOTH_WORD;
      3'h5: decode_layout = LAY_FIFO_C0_BYTE;
      3'h4: decode_layout = LAY_FIFO_C0_WORD;
      3'h7: decode_layout = LAY_FIFO_BOTH_BYTE;
      3'h6: decode_layout = LAY_FIFO_BOTH_WORD;
    endcase
  endfunction

endpackage

// *** hw/word_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes one clock; reset is asynchronous, active low.
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Draining side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [LW-1:0] count;

  wire do_wr = wr_valid && wr_ready;
  wire do_rd = rd_valid && rd_ready;

  assign wr_ready = count != LW'(DEPTH);
  assign rd_valid = count != '0;
  assign rd_data = mem[rd_ptr];
  assign level = count;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= bump(wr_ptr);
      if (do_rd) rd_ptr <= bump(rd_ptr);
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end

endmodule

// *** sim/output_sample_unpacker_sva.sv ***
// Assertions on the unpacker's sample outputs, keyed to control writes on its register port.
// Assumes software writes run=0 to the control register before every start.
`timescale 1ns/100ps
module output_sample_unpacker_sva #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [unpacker_pkg::ADDR_W-1:0] PADDR,
  input wire logic [unpacker_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  // Samples
  input wire logic [WORD_W-1:0] CH0_DATA,
  input wire logic CH0_VALID,
  input wire logic [WORD_W-1:0] CH1_DATA,
  input wire logic CH1_VALID,
  input wire logic SAMPLE_READY
);
  logic ctrl_wr;
  logic run_seen;
  logic [7:0] cfg;
  assign ctrl_wr = PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == unpacker_pkg::CTRL_OFF;
  // Setting captured at start only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_seen <= 1'b0;
      cfg <= 8'h00;
    end else if (ctrl_wr) begin
      run_seen <= PWDATA[0];
      if (PWDATA[0] && !run_seen) begin
        cfg <= PWDATA[7:0];
      end
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_hold;
    CH0_VALID && !SAMPLE_READY && !ctrl_wr |=> CH0_VALID && $stable(CH0_DATA)
      && $stable(CH1_DATA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("beat changed while stalled");
  property p_pair;
    CH1_VALID |-> CH0_VALID;
  endproperty
  a_pair: assert property (p_pair)
    else $error("channel 1 beat without channel 0");
  property p_byte;
    CH0_VALID && cfg[4] |-> CH0_DATA[15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte sample not zero extended");
  property p_single;
    CH0_VALID && !cfg[6] && !cfg[7] |-> !CH1_VALID && CH1_DATA == 16'h0000;
  endproperty
  a_single: assert property (p_single)
    else $error("channel 1 active in single layout");
  property p_both_byte;
    CH0_VALID && cfg[6] |-> CH1_VALID && CH1_DATA[15:8] == 8'h00;
  endproperty
  a_both_byte: assert property (p_both_byte)
    else $error("byte pair incomplete");
  property p_both_word;
    CH0_VALID && cfg[7] |-> CH1_VALID;
  endproperty
  a_both_word: assert property (p_both_word)
    else $error("word pair incomplete");
  property p_stop;
    ctrl_wr && !PWDATA[0] |=> !CH0_VALID [*2];
  endproperty
  a_stop: assert property (p_stop)
    else $error("beat after stop");
  property p_idle;
    CH0_VALID |-> run_seen;
  endproperty
  a_idle: assert property (p_idle)
    else $error("beat while stopped");
endmodule
bind output_sample_unpacker output_sample_unpacker_sva #(.WORD_W(WORD_W)) i_sva (
  .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .CH0_DATA(CH0_DATA), .CH0_VALID(CH0_VALID),
  .CH1_DATA(CH1_DATA), .CH1_VALID(CH1_VALID), .SAMPLE_READY(SAMPLE_READY));

// *** sim/word_source.sv ***
// Word source standing in for sample memory or host buffers.
// Assumes the bench queues words with push and sets slow for gaps.
`timescale 1ns/100ps
module word_source (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Word stream
  output logic [15:0] data = 16'h0000,
  output logic valid = 1'b0,
  input wire logic ready
);
  logic [15:0] q[$];
  logic slow = 1'b0;
  function automatic void push(input logic [15:0] w);
    q.push_back(w);
  endfunction
  // Holds each word until taken; idle data toggles
  always @(posedge clk) begin
    if (valid && ready) begin
      void'(q.pop_front());
    end
    if (nrst && q.size() > 0 && !(slow && valid && ready)) begin
      valid <= 1'b1;
      data <= q[0];
    end else begin
      valid <= 1'b0;
      data <= ~data;
    end
  end
endmodule

// *** sim/output_sample_unpacker_tb_top.sv ***
// Self-checking bench for the sample unpacker.
// Assumes the word source model and the bound checker.
`timescale 1ns/100ps
module output_sample_unpacker_tb_top;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] n;
    logic [63:0] e0;
    logic [63:0] e1;
  } row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] wdata;
  logic wvalid;
  logic wready;
  logic [15:0] ch0;
  logic ch0v;
  logic [15:0] ch1;
  logic ch1v;
  logic srdy = 1'b0;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int total_checks = 0;
  // Words a1b2 then c3d4; beat k in bits 16k+15..16k
  row_t rows [8] = '{
    '{8'h11, 3'd4, 64'h00c3_00d4_00a1_00b2, 64'h0},
    '{8'h21, 3'd2, 64'hc3d4_a1b2, 64'h0},
    '{8'h51, 3'd2, 64'h00d4_00b2, 64'h00c3_00a1},
    '{8'ha1, 3'd1, 64'ha1b2, 64'hc3d4},
    '{8'h13, 3'd2, 64'h00d4_00b2, 64'h0},
    '{8'h23, 3'd2, 64'hc3d4_a1b2, 64'h0},
    '{8'h53, 3'd2, 64'h00d4_00b2, 64'h00c3_00a1},
    '{8'ha3, 3'd1, 64'ha1b2, 64'hc3d4}
  };
  always #5 clk = ~clk;
  output_sample_unpacker i_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WORD_DATA(wdata), .WORD_VALID(wvalid),
    .WORD_READY(wready), .CH0_DATA(ch0), .CH0_VALID(ch0v), .CH1_DATA(ch1),
    .CH1_VALID(ch1v), .SAMPLE_READY(srdy));
  word_source i_src (.clk(clk), .nrst(nrst), .data(wdata), .valid(wvalid), .ready(wready));
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic beat(input logic [15:0] e0, input logic [15:0] e1, input logic v1);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(ch0v === 1'b1 && srdy === 1'b1) && n < 100);
    chk(ch0v, 1'b1);
    chk(ch0, e0);
    chk({ch1v, ch1}, {v1, e1});
    @(posedge clk);
  endtask
  initial begin
    #300000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, unpacker_pkg::CTRL_OFF, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h10);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, unpacker_pkg::STATUS_OFF, 32'hff, rd, er);
    chk(er, 1'b1);
    apb(1'b1, unpacker_pkg::CTRL_OFF, 32'h31, rd, er);
    apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
    chk(rd[1:0], 2'h2);
    for (int i = 0; i < 8; i++) begin
      i_src.slow = i[0];
      apb(1'b1, unpacker_pkg::CTRL_OFF, 32'h0, rd, er);
      i_src.push(16'ha1b2);
      i_src.push(16'hc3d4);
      apb(1'b1, unpacker_pkg::CTRL_OFF, {24'h0, rows[i].ctrl}, rd, er);
      apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
      chk(rd[6:0], {i[2:0], 4'h1});
      srdy <= 1'b1;
      for (int k = 0; k < rows[i].n; k++) begin
        beat(rows[i].e0[16*k+:16], rows[i].e1[16*k+:16], rows[i].ctrl[6] | rows[i].ctrl[7]);
      end
      srdy <= 1'b0;
    end
    // Fill under stall, change setting while running, then drain
    apb(1'b1, unpacker_pkg::CTRL_OFF, 32'h0, rd, er);
    apb(1'b1, unpacker_pkg::CTRL_OFF, 32'h21, rd, er);
    for (int j = 0; j < 10; j++) begin
      i_src.push(16'h1000 + 16'(j));
    end
    for (int k = 0; k < 100 && wready !== 1'b0; k++) begin
      @(negedge clk);
    end
    chk(wready, 1'b0);
    apb(1'b1, unpacker_pkg::CTRL_OFF, 32'h11, rd, er);
    apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
    chk(rd[11:0], 12'h811);
    srdy <= 1'b1;
    for (int j = 0; j < 10; j++) begin
      beat(16'h1000 + 16'(j), 16'h0, 1'b0);
    end
    srdy <= 1'b0;
    apb(1'b0, unpacker_pkg::COUNT_OFF, 32'h0, rd, er);
    chk(rd, 32'd10);
    apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
    chk(rd[11:0], 12'h011);
    // Reset in mid-run with a beat pending and words buffered
    for (int j = 0; j < 3; j++) begin
      i_src.push(16'h2000 + 16'(j));
    end
    repeat (10) @(posedge clk);
    chk(ch0v, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({ch0v, ch1v, wready, pready}, 4'h3);
    nrst <= 1'b1;
    apb(1'b0, unpacker_pkg::STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h10);
    apb(1'b0, unpacker_pkg::COUNT_OFF, 32'h0, rd, er);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
